// ### design/swr_core.sv
// Sleep entry, wake-up and reset-cause status flags
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Flags hold until a listed event
// - Clear pin pulse clears pin flag, leaves timeout and power-down flags unchanged
// - Only five events modify flags
// - Watchdog times out regardless of timeout flag
// - Sleep executes regardless of power-down flag
// - Power-down entered only by sleep instruction
// - Sleep clears watchdog, sets timeout, clears power-down
// - Pins hold their state during sleep
// - Watchdog reset never drives clear pin
// - Wake on clear, watchdog, or pin change
// - Every wake produces full device reset
// - Watchdog time-out clears timeout flag
// - Power-down flag set at power-up, cleared by sleep
// - Pin-wake flag records change versus latch
// - Any wake clears the watchdog counter
// - Awake watchdog reset gives 0,0,1
// - Awake clear reset: pin flag 0
// - Pin wake gives 1,1,0
module swr_core (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst, // Power-up reset, synchronous, active high
  input wire logic sleep_instr, // Core executes sleep, one-cycle pulse
  input wire logic watchdog_clear_instr, // Core executes watchdog clear, pulse
  input wire logic watchdog_enable, // Watchdog enabled by configuration
  input wire logic watchdog_tick, // Pulse from watchdog oscillator divider
  input wire logic clear_pin_enable, // Clear pin configured as clear
  input wire logic master_clear_pin_n, // Clear pin level, low asserts
  input wire logic wake_enable, // Wake-on-change enabled
  input wire logic [swr_pkg::PORT_W-1:0] port_in, // Port input levels
  input wire logic port_access, // File or bit operation on the port
  input wire logic [swr_pkg::PORT_W-1:0] port_out_run, // Port drive value from core
  input wire logic [swr_pkg::PORT_W-1:0] port_oe_run, // Port drive enables from core
  output logic [swr_pkg::PORT_W-1:0] port_out, // Pin output values
  output logic [swr_pkg::PORT_W-1:0] port_oe, // Pin output enables
  output logic device_reset, // Full device reset request, level
  output logic osc_driver_on, // Oscillator driver enable
  output logic sleeping, // Device in power-down
  output logic master_clear_out, // Clear pin output, never driven
  output logic master_clear_oe, // Clear pin output enable, always low
  output swr_pkg::swr_flags_type flags // Reset-cause flags
);
  import swr_pkg::*;

  swr_state_type state_q;
  swr_state_type state_d;
  swr_flags_type flags_q;
  swr_flags_type flags_d;
  logic [PORT_W-1:0] latch_q;
  logic [PORT_W-1:0] latch_d;
  logic [PORT_W-1:0] hold_out_q;
  logic [PORT_W-1:0] hold_out_d;
  logic [PORT_W-1:0] hold_oe_q;
  logic [PORT_W-1:0] hold_oe_d;
  logic [1:0] rcnt_q;
  logic [1:0] rcnt_d;
  logic clear_seen_q;
  logic clear_seen_d;
  logic watchdog_clear;
  logic watchdog_timeout;
  logic pin_change;
  logic clear_wake;
  logic clear_run;

  // Change detector shared by sleep wake test and its assertion
  function automatic logic changed(input logic [PORT_W-1:0] now, input logic [PORT_W-1:0] ref_v);
    changed = |((now ^ ref_v) & WAKE_MASK);
  endfunction : changed

  swr_watchdog u_watchdog (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(watchdog_enable),
    .tick(watchdog_tick),
    .clear(watchdog_clear),
    .timeout(watchdog_timeout)
  );

  // Wake sources; the clear pin counts only when configured for clear
  always_comb begin
    pin_change = wake_enable && changed(port_in, latch_q);
    clear_wake = clear_pin_enable && !master_clear_pin_n && (state_q == SWR_SLEEP);
    clear_run = clear_pin_enable && !master_clear_pin_n && (state_q == SWR_RUN) && !clear_seen_q;
    // Watchdog cleared by the clear instruction, on sleep entry and on every wake
    watchdog_clear = watchdog_clear_instr || (state_q == SWR_RUN && sleep_instr) || (state_q == SWR_WRESET);
  end

  // Sleep state machine and flag updates
  always_comb begin
    state_d = state_q;
    flags_d = flags_q; // Flags hold by default; only the events below change them
    latch_d = latch_q;
    hold_out_d = hold_out_q;
    hold_oe_d = hold_oe_q;
    rcnt_d = rcnt_q;
    clear_seen_d = clear_pin_enable && !master_clear_pin_n;
    case (state_q)
      SWR_RUN: begin
        if (port_access) begin
          latch_d = port_in; // Reference for change detection
        end
        if (watchdog_timeout) begin
          // Awake time-out: timeout flag cleared, power-down flag reads 1, pin flag 0
          flags_d.timeout_flag_n = 1'b0;
          flags_d.powerdown_flag_n = 1'b1;
          flags_d.pin_wake_flag = 1'b0;
          state_d = SWR_WRESET;
          rcnt_d = RST_LEN;
        end else if (clear_run) begin
          // Awake clear pin: only the pin flag changes, to 0
          flags_d.pin_wake_flag = 1'b0;
          state_d = SWR_WRESET;
          rcnt_d = RST_LEN;
        end else if (sleep_instr) begin
          // Sleep runs whatever the power-down flag holds; sole way into power-down
          flags_d.timeout_flag_n = 1'b1;
          flags_d.powerdown_flag_n = 1'b0;
          hold_out_d = port_out_run; // Freeze pin state
          hold_oe_d = port_oe_run;
          state_d = SWR_SLEEP;
        end else if (watchdog_clear_instr) begin
          flags_d.timeout_flag_n = 1'b1;
          flags_d.powerdown_flag_n = 1'b1;
        end
      end
      SWR_SLEEP: begin
        // Watchdog wake has priority as it also clears the timeout flag
        if (watchdog_timeout) begin
          flags_d.timeout_flag_n = 1'b0;
          flags_d.pin_wake_flag = 1'b0;
          state_d = SWR_WRESET;
          rcnt_d = RST_LEN;
        end else if (clear_wake) begin
          flags_d.pin_wake_flag = 1'b0; // Clear wake leaves timeout and power-down flags
          state_d = SWR_WRESET;
          rcnt_d = RST_LEN;
        end else if (pin_change) begin
          flags_d.pin_wake_flag = 1'b1;
          flags_d.timeout_flag_n = 1'b1;
          flags_d.powerdown_flag_n = 1'b0;
          state_d = SWR_WRESET;
          rcnt_d = RST_LEN;
        end
      end
      SWR_WRESET: begin
        // Hold full reset a few cycles, then run again
        if (rcnt_q == CNT_ZERO) begin
          state_d = SWR_RUN;
        end else begin
          rcnt_d = rcnt_q - 2'h1;
        end
      end
      default: begin
        state_d = SWR_RUN;
      end
    endcase
  end

  // Registers; power-up values of the flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= SWR_RUN;
      flags_q <= FLAGS_PWRUP;
      latch_q <= '0;
      hold_out_q <= '0;
      hold_oe_q <= '0;
      rcnt_q <= CNT_ZERO;
      clear_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      flags_q <= flags_d;
      latch_q <= latch_d;
      hold_out_q <= hold_out_d;
      hold_oe_q <= hold_oe_d;
      rcnt_q <= rcnt_d;
      clear_seen_q <= clear_seen_d;
    end
  end

  // Pins follow the core when awake and the frozen copy while asleep
  assign port_out = (state_q == SWR_SLEEP) ? hold_out_q : port_out_run;
  assign port_oe = (state_q == SWR_SLEEP) ? hold_oe_q : port_oe_run;
  assign sleeping = (state_q == SWR_SLEEP);
  assign osc_driver_on = (state_q != SWR_SLEEP);
  assign device_reset = (state_q == SWR_WRESET);
  // The clear pin is input only; a watchdog reset stays internal
  assign master_clear_out = 1'b0;
  assign master_clear_oe = 1'b0;
  assign flags = flags_q;

  // Checks
  sequence s_sleep_go;
    (state_q == SWR_RUN) && sleep_instr && !watchdog_timeout && !clear_run;
  endsequence

  // A wake is the step out of sleep, followed by the fixed reset pulse
  sequence s_wake_exit;
    sleeping ##1 !sleeping;
  endsequence

  sequence s_reset_pulse;
    device_reset [*4] ##1 !device_reset;
  endsequence

  a_sleep_flags: assert property (@(posedge sys_clk) disable iff (rst)
    s_sleep_go |=> sleeping && flags.timeout_flag_n && !flags.powerdown_flag_n && !osc_driver_on)
    else $error("sleep entry flags wrong");

  a_sleep_only_instr: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(sleeping) |-> $past(sleep_instr))
    else $error("power-down entered without sleep");

  a_wdt_clears_to: assert property (@(posedge sys_clk) disable iff (rst)
    watchdog_timeout && state_q != SWR_WRESET |=> !flags.timeout_flag_n && device_reset)
    else $error("time-out did not clear flag");

  a_awake_timeout_flags: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == SWR_RUN && watchdog_timeout
    |=> !flags.pin_wake_flag && !flags.timeout_flag_n && flags.powerdown_flag_n)
    else $error("awake time-out flags wrong");

  a_wake_reset: assert property (@(posedge sys_clk) disable iff (rst)
    s_wake_exit |-> s_reset_pulse)
    else $error("wake did not give full reset");

  a_pin_wake: assert property (@(posedge sys_clk) disable iff (rst)
    sleeping && !watchdog_timeout && !clear_wake && wake_enable && changed(port_in, latch_q)
    |=> flags.pin_wake_flag && flags.timeout_flag_n && !flags.powerdown_flag_n)
    else $error("pin wake flags wrong");

  a_clear_wake_flags: assert property (@(posedge sys_clk) disable iff (rst)
    sleeping && clear_wake && !watchdog_timeout |=> device_reset && !flags.pin_wake_flag
      && $stable(flags.timeout_flag_n) && $stable(flags.powerdown_flag_n))
    else $error("clear wake flags wrong");

  a_clear_instr_flags: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == SWR_RUN && watchdog_clear_instr && !sleep_instr && !watchdog_timeout && !clear_run
    |=> flags.timeout_flag_n && flags.powerdown_flag_n && $stable(flags.pin_wake_flag))
    else $error("watchdog clear flags wrong");

  a_flags_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !watchdog_timeout && !sleep_instr && !watchdog_clear_instr && !pin_change && !clear_run && !clear_wake
    |=> $stable(flags))
    else $error("flags changed without event");

  a_pins_frozen: assert property (@(posedge sys_clk) disable iff (rst)
    sleeping ##1 sleeping |-> $stable(port_out) && $stable(port_oe))
    else $error("pins moved during sleep");

  a_master_clear_pin_awake: assert property (@(posedge sys_clk) disable iff (rst)
    clear_run && !watchdog_timeout |=> !flags.pin_wake_flag && $stable(flags.timeout_flag_n)
      && $stable(flags.powerdown_flag_n))
    else $error("clear reset changed flags");

  a_clear_pin_idle: assert property (@(posedge sys_clk) disable iff (rst)
    device_reset |-> !master_clear_oe)
    else $error("clear pin driven");
endmodule : swr_core
`default_nettype wire

// ### design/swr_pkg.sv
// Package for the sleep, wake and reset-cause block
package swr_pkg;
  // Wake pin count and positions within the port
  localparam int unsigned WAKE_PINS = 4;
  localparam int unsigned PORT_W = 6;
  localparam logic [PORT_W-1:0] WAKE_MASK = 6'h1b; // Pins 0, 1, 3, 4
  // Status bit positions of the flags
  localparam int unsigned TIMEOUT_BIT = 4;
  localparam int unsigned POWERDOWN_BIT = 3;
  localparam int unsigned PWF_BIT = 7;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // Watchdog width and default period in its own ticks
  localparam int unsigned WATCHDOG_W = 8;
  localparam logic [WATCHDOG_W-1:0] WATCHDOG_LAST = 8'hff;
  // Wake-reset counter start; the pulse lasts one cycle longer, 4 cycles
  localparam logic [1:0] RST_LEN = 2'h3;
  localparam logic [1:0] CNT_ZERO = 2'h0;

  typedef enum logic [1:0] {SWR_RUN, SWR_SLEEP, SWR_WRESET} swr_state_type;

  // Reset-cause flags as one carrier
  typedef struct packed {
    logic pin_wake_flag;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } swr_flags_type;

  localparam swr_flags_type FLAGS_PWRUP = '{pin_wake_flag: 1'b0, timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
endpackage : swr_pkg

// ### design/swr_watchdog.sv
// Watchdog counter clocked by enable ticks from its own oscillator
`timescale 1ns/100ps
`default_nettype none
module swr_watchdog (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Power-up reset, synchronous, active high
  input wire logic enable, // Watchdog enabled by configuration
  input wire logic tick, // One-cycle pulse from watchdog oscillator
  input wire logic clear, // Clear the count
  output logic timeout // One-cycle pulse at wrap
);
  import swr_pkg::*;

  logic [WATCHDOG_W-1:0] count_q;
  logic [WATCHDOG_W-1:0] count_d;
  logic timeout_q;
  logic timeout_d;

  // Count ticks; no status flag gates the count
  always_comb begin
    count_d = count_q;
    timeout_d = 1'b0;
    if (clear || !enable) begin
      count_d = '0;
    end else if (tick) begin
      count_d = count_q + 8'h01;
      timeout_d = (count_q == WATCHDOG_LAST);
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= '0;
      timeout_q <= 1'b0;
    end else begin
      count_q <= count_d;
      timeout_q <= timeout_d;
    end
  end

  assign timeout = timeout_q;
endmodule : swr_watchdog
`default_nettype wire

// ### verif/swr_cpu_model.sv
// Core model that issues sleep and watchdog-clear instructions
`timescale 1ns/100ps
`default_nettype none
module swr_cpu_model (
  input wire logic want_sleep, // Bench asks for sleep
  input wire logic want_clear, // Bench asks for watchdog clear
  input wire logic device_reset, // Core held in reset
  input wire logic sleeping, // Core clock stopped
  output logic sleep_instr, // Sleep executed, one cycle
  output logic watchdog_clear_instr // Watchdog clear executed, one cycle
);
  // A core in reset or asleep fetches nothing, so it issues no instruction
  assign sleep_instr = want_sleep & ~device_reset & ~sleeping;
  assign watchdog_clear_instr = want_clear & ~device_reset & ~sleeping;
endmodule : swr_cpu_model
`default_nettype wire

// ### verif/swr_core_tb.sv
// Self-checking bench for the sleep, wake and reset-cause block
`timescale 1ns/100ps
`default_nettype none
module swr_core_tb;
  import swr_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, want_sleep = 1'b0, want_clear = 1'b0, port_access = 1'b0;
  logic watchdog_enable = 1'b0, watchdog_tick = 1'b0, master_clear_pin_n = 1'b1;
  logic clear_pin_enable = 1'b1, wake_enable = 1'b1;
  logic [PORT_W-1:0] port_in = 6'h00, port_out_run = 6'h00, port_oe_run = 6'h00, port_out, port_oe, h_out, h_oe;
  logic sleep_instr, watchdog_clear_instr, device_reset, osc_driver_on, sleeping, master_clear_out, master_clear_oe;
  logic [2:0] exp_f, first_f;
  logic first_oe;
  swr_flags_type flags;
  int errors = 0, total_checks = 0, seed = 31131, span, len;
  int wake_pins [4] = '{0, 1, 3, 4};
  always #5 sys_clk = ~sys_clk;
  swr_cpu_model cpu (.want_sleep(want_sleep), .want_clear(want_clear), .device_reset(device_reset),
    .sleeping(sleeping), .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr));
  swr_core DUT (.sys_clk(sys_clk), .rst(rst), .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr),
    .watchdog_enable(watchdog_enable), .watchdog_tick(watchdog_tick), .clear_pin_enable(clear_pin_enable),
    .master_clear_pin_n(master_clear_pin_n),
    .wake_enable(wake_enable), .port_in(port_in), .port_access(port_access), .port_out_run(port_out_run),
    .port_oe_run(port_oe_run), .port_out(port_out), .port_oe(port_oe), .device_reset(device_reset),
    .osc_driver_on(osc_driver_on), .sleeping(sleeping), .master_clear_out(master_clear_out),
    .master_clear_oe(master_clear_oe), .flags(flags));
  // Flag model: next {pin wake, timeout_n, powerdown_n} after each event
  function automatic logic [2:0] model(input int ev, input logic [2:0] f);
    case (ev)
      0: return 3'b001; // Awake watchdog reset
      1: return {f[2], 2'b11}; // Watchdog clear
      2: return {f[2], 2'b10}; // Sleep
      3: return 3'b110; // Pin-change wake
      4: return 3'b010; // Clear-pin wake
      5: return {1'b0, f[1:0]}; // Awake clear-pin reset
      6: return 3'b000; // Watchdog wake
      default: return 3'b011; // Power-up
    endcase
  endfunction : model
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Wait for a reset pulse and measure it; the bound stops a hang
  task automatic go(input int limit);
    span = 0;
    while (device_reset !== 1'b1 && span < limit) begin
      cyc(1);
      span++;
    end
    first_f = flags;
    first_oe = master_clear_oe;
    len = 0;
    while (device_reset === 1'b1 && len < 20) begin
      cyc(1);
      len++;
    end
    if (span >= limit) begin
      errors++;
      $display("wrong value reset wait expected pulse seen none");
      print_verdict();
    end
  endtask : go
  // Latch the port as change reference, then sleep, so old changes cannot wake it
  task automatic nap();
    port_access = 1'b1;
    cyc(1);
    port_access = 1'b0;
    want_sleep = 1'b1;
    cyc(1);
    want_sleep = 1'b0;
  endtask : nap
  initial begin
    cyc(8);
    rst = 1'b0;
    cyc(1);
    exp_f = model(7, 3'b000);
    check("pwrup flags", flags, exp_f);
    // Second time-out runs with the timeout flag already low
    watchdog_enable = 1'b1;
    watchdog_tick = 1'b1;
    repeat (2) begin
      go(400);
      exp_f = model(0, exp_f);
      check("watchdog flags", first_f, exp_f);
      check("watchdog len", 16'(len), 16'h0004);
      check("clear pin oe", {first_oe, master_clear_out}, 16'h0000);
    end
    watchdog_enable = 1'b0;
    $display("test awake watchdog done");
    want_clear = 1'b1;
    cyc(1);
    want_clear = 1'b0;
    exp_f = model(1, exp_f);
    check("watchdog clear flags", flags, exp_f);
    port_in = 6'($random(seed));
    port_out_run = 6'($random(seed));
    port_oe_run = 6'($random(seed));
    cyc(1);
    check("awake out", {port_oe, port_out}, {port_oe_run, port_out_run});
    h_out = port_out_run;
    h_oe = port_oe_run;
    nap();
    exp_f = model(2, exp_f);
    check("sleep flags", flags, exp_f);
    check("sleep state", {sleeping, osc_driver_on}, 16'h0002);
    port_out_run = ~h_out;
    port_oe_run = ~h_oe;
    port_in[2] = ~port_in[2];
    cyc(3);
    check("held out", {port_oe, port_out}, {h_oe, h_out});
    check("pin 2 ignored", sleeping, 1'b1);
    // A wake pin change with wake-on-change off must not wake; turning it on then must
    wake_enable = 1'b0;
    port_in[wake_pins[$random(seed) & 3]] ^= 1'b1;
    cyc(3);
    check("wake off ignored", sleeping, 1'b1);
    wake_enable = 1'b1;
    go(20);
    exp_f = model(3, exp_f);
    check("pin wake flags", first_f, exp_f);
    check("pin wake len", 16'(len), 16'h0004);
    cyc(5);
    check("flags hold", flags, exp_f);
    $display("test pin wake done");
    nap();
    check("sleep with power-down low", sleeping, 1'b1);
    // Clear pin not configured as clear must not wake the device
    clear_pin_enable = 1'b0;
    master_clear_pin_n = 1'b0;
    cyc(2);
    check("clear pin off", sleeping, 1'b1);
    clear_pin_enable = 1'b1;
    master_clear_pin_n = 1'b1;
    cyc(1);
    master_clear_pin_n = 1'b0;
    cyc(1);
    master_clear_pin_n = 1'b1;
    go(20);
    exp_f = model(4, model(2, exp_f));
    check("clear wake flags", first_f, exp_f);
    master_clear_pin_n = 1'b0;
    cyc(2);
    master_clear_pin_n = 1'b1;
    go(20);
    exp_f = model(5, exp_f);
    check("awake clear flags", first_f, exp_f);
    $display("test clear pin done");
    // Pre-run the watchdog so a missed clear on sleep would wake early
    watchdog_enable = 1'b1;
    cyc(200);
    nap();
    go(400);
    exp_f = model(6, exp_f);
    check("watchdog wake flags", first_f, exp_f);
    check("watchdog cleared on sleep", span > 200, 1'b1);
    // Clear-pin wake part way into sleep; a count kept over the wake would time out early
    nap();
    cyc(150);
    master_clear_pin_n = 1'b0;
    cyc(1);
    master_clear_pin_n = 1'b1;
    go(20);
    exp_f = model(4, model(2, exp_f));
    check("clear wake again", first_f, exp_f);
    // Awake time-out with the power-down flag low before it
    go(400);
    check("watchdog cleared on wake", span > 200, 1'b1);
    check("watchdog flags again", first_f, model(0, exp_f));
    $display("test watchdog wake done");
    print_verdict();
  end
endmodule : swr_core_tb
`default_nettype wire
